// >>> design/conv_serial_ctrl.sv
`timescale 1ns/10ps

module conv_serial_ctrl
	import conv_serial_pkg::*;
(
	input wire logic clock_in, // system clock, 200 mhz
	input wire logic rst_in, // async reset, active high
	input wire logic sclk_in, // serial clock from host
	input wire logic cs_n_in, // chip select, active low
	input wire logic din_in, // serial data in
	output logic dout_out, // serial data out
	input wire logic adc_result_valid_in, // one-cycle push of an adc result
	input wire logic [ADC_W-1:0] adc_result_in, // adc result
	input wire logic temp_result_valid_in, // one-cycle push of a temperature result
	input wire logic [TEMP_W-1:0] temp_result_in, // temperature with sub-bits
	input wire logic dac_load_strobe_n_in, // dac load strobe pin, active low
	input wire logic wakeup_level_select_in, // dac wake-up strap pin
	output logic [DAC_CH*DAC_W-1:0] dac_code_out, // output codes, channel 0 low
	output logic [DAC_CH-1:0] dac_buffer_pd_out, // output buffer powered down
	output logic dac_pull_to_ref_out, // pull resistor goes to reference
	output logic clock_mode_sel_hi_out, // clock mode bit 1
	output logic clock_mode_sel_lo_out, // clock mode bit 0
	output logic internal_osc_en_out, // internal oscillator runs
	output logic sclk_timed_conv_out, // conversions timed by sclk
	output logic ext_acq_en_out, // externally timed acquisition allowed
	output logic gp_pin_a0_out, // general-purpose pin a0
	output logic gp_pin_a1_out, // general-purpose pin a1
	output logic gp_pin_c0_out, // general-purpose pin c0
	output logic gp_pin_c1_out, // general-purpose pin c1
	output logic [CNT_W-1:0] fifo_count_out, // unread adc results
	output logic temp_pending_out // unread temperature result
);

	// link-side state
	logic [4:0] bit_cnt_q;
	logic [SR_W-1:0] sr_q;
	frame_state_t fr_state_q;
	logic [7:0] first_byte_q;
	logic cmd_tgl_q;
	logic rd_tgl_q;
	cmd_kind_t cmd_kind_q;
	logic [WORD_W-1:0] cmd_data_q;
	logic [7:0] fbyte_w;
	logic [WORD_W-1:0] word_w;
	logic post_setup_w;
	logic post_gpio_w;
	logic post_dac_w;

	// system-side state
	logic [2:0] cmd_sync_q;
	logic [2:0] rd_sync_q;
	logic [1:0] cs_sync_q;
	logic [1:0] dac_load_strobe_n_sync_q;
	logic [1:0] wake_sync_q;
	logic cmd_ev_w;
	logic rd_ev_w;
	logic frame_w;
	logic dac_load_strobe_n_w;
	logic [2:0] boot_q;
	logic boot_load_w;
	logic wake_hi_q;
	logic [ADC_W-1:0] mem_q [FIFO_DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_W-1:0] count_q;
	logic fifo_full_w;
	logic pop_fifo_w;
	logic [TEMP_W-1:0] temp_q;
	logic temp_valid_q;
	logic [WORD_W-1:0] head_q;
	logic src_temp_q;
	logic src_fifo_q;
	logic [7:0] setup_q;
	logic [3:0] gpio_q;
	logic [DAC_W-1:0] dac_in_q [DAC_CH];
	logic [DAC_W-1:0] dac_out_q [DAC_CH];
	logic [DAC_CH-1:0] buf_pd_q;
	logic [1:0] dac_op_w;
	logic [1:0] dac_ch_w;
	logic [DAC_W-1:0] dac_data_w;
	logic [1:0] clk_mode_w;

	// bytes as they complete on this falling edge
	assign fbyte_w = {sr_q[6:0], din_in};
	assign word_w = {sr_q[WORD_W-2:0], din_in};

	// command completion, decoded from the frame state
	assign post_setup_w = (fr_state_q == FR_CMD) && (bit_cnt_q == BIT_CMD_LAST)
		&& (fbyte_w[7:6] == CMD_SETUP_TAG);
	assign post_gpio_w = (fr_state_q == FR_DATA) && (bit_cnt_q == BIT_GPIO_LAST)
		&& (first_byte_q == CMD_GPIO_WR);
	assign post_dac_w = (fr_state_q == FR_DATA) && (bit_cnt_q == BIT_DAC_LAST)
		&& (first_byte_q[7:4] == CMD_DAC_TAG);

	// frame shifter; cs high holds it in reset so partial commands vanish
	always_ff @(negedge sclk_in or posedge rst_in or posedge cs_n_in) begin
		if (rst_in || cs_n_in) begin
			bit_cnt_q <= 5'h00;
			sr_q <= 24'h000000;
			fr_state_q <= FR_CMD;
			first_byte_q <= 8'h00;
		end else begin
			sr_q <= {sr_q[SR_W-2:0], din_in};
			if (bit_cnt_q != BIT_CNT_MAX) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
			case (fr_state_q)
				FR_CMD: begin
					if (bit_cnt_q == BIT_CMD_LAST) begin
						first_byte_q <= fbyte_w;
						// only the high nibble picks a dac write
						if (fbyte_w[7:4] == CMD_DAC_TAG) begin
							fr_state_q <= FR_DATA;
						end else if (fbyte_w == CMD_GPIO_WR) begin
							fr_state_q <= FR_DATA;
						end else begin
							fr_state_q <= FR_DONE;
						end
					end
				end
				FR_DATA: begin
					if (post_gpio_w || post_dac_w) begin
						fr_state_q <= FR_DONE;
					end
				end
				FR_DONE: begin
					fr_state_q <= FR_DONE;
				end
				default: begin
					fr_state_q <= FR_DONE;
				end
			endcase
		end
	end

	// finished commands are posted with a toggle; word stays until the next one
	always_ff @(negedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_tgl_q <= 1'b0;
			cmd_kind_q <= CMD_SETUP;
			cmd_data_q <= 16'h0000;
		end else if (post_setup_w) begin
			cmd_tgl_q <= ~cmd_tgl_q;
			cmd_kind_q <= CMD_SETUP;
			cmd_data_q <= {8'h00, fbyte_w};
		end else if (post_gpio_w) begin
			cmd_tgl_q <= ~cmd_tgl_q;
			cmd_kind_q <= CMD_GPIO;
			cmd_data_q <= word_w;
		end else if (post_dac_w) begin
			cmd_tgl_q <= ~cmd_tgl_q;
			cmd_kind_q <= CMD_DAC;
			cmd_data_q <= word_w;
		end
	end

	// readout done once the sixteenth bit has been shifted out
	always_ff @(negedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_tgl_q <= 1'b0;
		end else if (!cs_n_in && (bit_cnt_q == BIT_RD_LAST)) begin
			rd_tgl_q <= ~rd_tgl_q;
		end
	end

	// serial output; head word is frozen by the system side during a frame
	always_comb begin
		dout_out = 1'b0;
		if (!cs_n_in && (bit_cnt_q < 5'h10)) begin
			dout_out = head_q[4'hf - bit_cnt_q[3:0]];
		end
	end

	// synchronisers for link events and pins
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_sync_q <= 3'h0;
			rd_sync_q <= 3'h0;
			cs_sync_q <= 2'h3;
			dac_load_strobe_n_sync_q <= 2'h3;
			wake_sync_q <= 2'h0;
		end else begin
			cmd_sync_q <= {cmd_sync_q[1:0], cmd_tgl_q};
			rd_sync_q <= {rd_sync_q[1:0], rd_tgl_q};
			cs_sync_q <= {cs_sync_q[0], cs_n_in};
			dac_load_strobe_n_sync_q <= {dac_load_strobe_n_sync_q[0], dac_load_strobe_n_in};
			wake_sync_q <= {wake_sync_q[0], wakeup_level_select_in};
		end
	end

	assign cmd_ev_w = cmd_sync_q[2] ^ cmd_sync_q[1];
	assign rd_ev_w = rd_sync_q[2] ^ rd_sync_q[1];
	assign frame_w = ~cs_sync_q[1];
	assign dac_load_strobe_n_w = ~dac_load_strobe_n_sync_q[1];

	// strap is taken once the synchroniser has settled after reset
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			boot_q <= BOOT_INIT;
		end else begin
			boot_q <= {1'b0, boot_q[2:1]}; // walks 111, 011, 001, 000
		end
	end
	assign boot_load_w = (boot_q == BOOT_LOAD);

	// pull direction follows the strap taken at the same edge as the wake code
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wake_hi_q <= 1'b0;
		end else if (boot_load_w) begin
			wake_hi_q <= wake_sync_q[1];
		end
	end

	// result storage, written at the write pointer
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (adc_result_valid_in) begin
			mem_q[wr_ptr_q] <= adc_result_in;
		end
	end

	assign fifo_full_w = (count_q == FIFO_FULL);
	assign pop_fifo_w = rd_ev_w && src_fifo_q && (count_q != 5'h00);

	// pointers; a push into a full store also moves the oldest out
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			count_q <= 5'h00;
		end else begin
			if (adc_result_valid_in) begin
				wr_ptr_q <= wr_ptr_q + 4'h1;
			end
			if (pop_fifo_w || (adc_result_valid_in && fifo_full_w)) begin
				rd_ptr_q <= rd_ptr_q + 4'h1;
			end
			if (adc_result_valid_in && !fifo_full_w && !pop_fifo_w) begin
				count_q <= count_q + 5'h01;
			end else if (pop_fifo_w && !adc_result_valid_in) begin
				count_q <= count_q - 5'h01;
			end
		end
	end

	// temperature slot; a new result wins over a same-cycle read
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			temp_q <= 12'h000;
			temp_valid_q <= 1'b0;
		end else if (temp_result_valid_in) begin
			temp_q <= temp_result_in;
			temp_valid_q <= 1'b1;
		end else if (rd_ev_w && src_temp_q) begin
			temp_valid_q <= 1'b0;
		end
	end

	// head word follows the store between frames and holds during one
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			head_q <= 16'h0000;
			src_temp_q <= 1'b0;
			src_fifo_q <= 1'b0;
		end else if (!frame_w) begin
			src_temp_q <= temp_valid_q;
			src_fifo_q <= !temp_valid_q && (count_q != 5'h00);
			if (temp_valid_q) begin
				head_q <= {LEAD_ZEROS, temp_q};
			end else if (count_q != 5'h00) begin
				head_q <= {LEAD_ZEROS, mem_q[rd_ptr_q], ADC_SUB_BITS};
			end else begin
				head_q <= 16'h0000;
			end
		end
	end

	// setup register holds the clock mode
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			setup_q <= SETUP_RESET;
		end else if (cmd_ev_w && (cmd_kind_q == CMD_SETUP)) begin
			setup_q <= cmd_data_q[7:0];
		end
	end
	assign clk_mode_w = {setup_q[CKSEL_HI_POS], setup_q[CKSEL_LO_POS]};

	// clock mode decode
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			clock_mode_sel_hi_out <= 1'b1;
			clock_mode_sel_lo_out <= 1'b0;
			internal_osc_en_out <= 1'b1;
			sclk_timed_conv_out <= 1'b0;
			ext_acq_en_out <= 1'b0;
		end else begin
			clock_mode_sel_hi_out <= clk_mode_w[1];
			clock_mode_sel_lo_out <= clk_mode_w[0];
			internal_osc_en_out <= (clk_mode_w != CLK_MODE_EXT);
			sclk_timed_conv_out <= (clk_mode_w == CLK_MODE_EXT);
			ext_acq_en_out <= (clk_mode_w == CLK_MODE_EXT_ACQ);
		end
	end

	// general-purpose pin write from the single data byte
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			gpio_q <= 4'h0;
		end else if (cmd_ev_w && (cmd_kind_q == CMD_GPIO)) begin
			gpio_q <= cmd_data_q[3:0];
		end
	end

	assign gp_pin_a0_out = gpio_q[GP_A0_POS];
	assign gp_pin_a1_out = gpio_q[GP_A1_POS];
	assign gp_pin_c0_out = gpio_q[GP_C0_POS];
	assign gp_pin_c1_out = gpio_q[GP_C1_POS];

	// dac interface word fields
	assign dac_op_w = cmd_data_q[DAC_OP_POS+1:DAC_OP_POS];
	assign dac_ch_w = cmd_data_q[DAC_CH_POS+1:DAC_CH_POS];
	assign dac_data_w = cmd_data_q[DAC_DATA_POS+DAC_W-1:DAC_DATA_POS];

	// per-channel double buffer
	for (genvar ch = 0; ch < DAC_CH; ch++) begin : g_dac
		logic sel_w;
		logic wr_in_w;
		logic ld_w;
		assign sel_w = (dac_ch_w == 2'(ch));
		assign wr_in_w = cmd_ev_w && (cmd_kind_q == CMD_DAC)
			&& ((dac_op_w == DAC_OP_ALL)
			|| (sel_w && ((dac_op_w == DAC_OP_INPUT) || (dac_op_w == DAC_OP_INPUT_LOAD))));
		assign ld_w = dac_load_strobe_n_w || (cmd_ev_w && (cmd_kind_q == CMD_DAC)
			&& ((dac_op_w == DAC_OP_ALL) || (dac_op_w == DAC_OP_LOAD_ALL)
			|| (sel_w && (dac_op_w == DAC_OP_INPUT_LOAD))));
		always_ff @(posedge clock_in or posedge rst_in) begin
			if (rst_in) begin
				dac_in_q[ch] <= '0;
				dac_out_q[ch] <= '0;
				buf_pd_q[ch] <= 1'b1;
			end else if (boot_load_w) begin
				// wake code from the strap, buffers stay down
				if (wake_sync_q[1]) begin
					dac_in_q[ch] <= DAC_WAKE_HIGH[DAC_W-1:0];
					dac_out_q[ch] <= DAC_WAKE_HIGH[DAC_W-1:0];
				end else begin
					dac_in_q[ch] <= DAC_WAKE_LOW[DAC_W-1:0];
					dac_out_q[ch] <= DAC_WAKE_LOW[DAC_W-1:0];
				end
				buf_pd_q[ch] <= 1'b1;
			end else begin
				if (wr_in_w) begin
					dac_in_q[ch] <= dac_data_w;
				end
				if (ld_w) begin
					dac_out_q[ch] <= wr_in_w ? dac_data_w : dac_in_q[ch];
					buf_pd_q[ch] <= 1'b0;
				end
			end
		end
		assign dac_code_out[ch*DAC_W +: DAC_W] = dac_out_q[ch];
	end

	assign dac_buffer_pd_out = buf_pd_q;
	assign dac_pull_to_ref_out = wake_hi_q;
	assign fifo_count_out = count_q;
	assign temp_pending_out = temp_valid_q;

endmodule : conv_serial_ctrl

// >>> design/conv_serial_pkg.sv
package conv_serial_pkg;
	// result store geometry
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int ADC_W = 10;
	localparam int TEMP_W = 12;
	localparam int WORD_W = 16;
	localparam int SR_W = 24;
	localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;
	localparam logic [1:0] ADC_SUB_BITS = 2'h0;
	// frame bit positions (count of bits already taken)
	localparam logic [4:0] BIT_CMD_LAST = 5'h07;
	localparam logic [4:0] BIT_RD_LAST = 5'h0f;
	localparam logic [4:0] BIT_GPIO_LAST = 5'h0f;
	localparam logic [4:0] BIT_DAC_LAST = 5'h17;
	localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
	// command byte codes
	localparam logic [1:0] CMD_SETUP_TAG = 2'h1;
	localparam logic [3:0] CMD_DAC_TAG = 4'h1;
	localparam logic [7:0] CMD_GPIO_WR = 8'h02;
	// setup register
	localparam logic [7:0] SETUP_RESET = 8'h28;
	localparam int CKSEL_HI_POS = 5;
	localparam int CKSEL_LO_POS = 4;
	localparam logic [1:0] CLK_MODE_EXT = 2'h3;
	localparam logic [1:0] CLK_MODE_EXT_ACQ = 2'h1;
	// dac
	localparam int DAC_W = 10;
	localparam int DAC_CH = 4;
	localparam logic [11:0] DAC_WAKE_LOW = 12'h000;
	localparam logic [11:0] DAC_WAKE_HIGH = 12'hfff;
	localparam int DAC_OP_POS = 14;
	localparam int DAC_CH_POS = 12;
	localparam int DAC_DATA_POS = 2;
	localparam logic [1:0] DAC_OP_INPUT = 2'h0;
	localparam logic [1:0] DAC_OP_INPUT_LOAD = 2'h1;
	localparam logic [1:0] DAC_OP_LOAD_ALL = 2'h2;
	localparam logic [1:0] DAC_OP_ALL = 2'h3;
	// general-purpose pin bits of the write data byte
	localparam int GP_A0_POS = 0;
	localparam int GP_A1_POS = 1;
	localparam int GP_C0_POS = 2;
	localparam int GP_C1_POS = 3;
	// strap capture sequence after reset release
	localparam logic [2:0] BOOT_INIT = 3'h7;
	localparam logic [2:0] BOOT_LOAD = 3'h1;
	typedef enum logic [1:0] {FR_CMD = 2'b00, FR_DATA = 2'b01, FR_DONE = 2'b11} frame_state_t;
	typedef enum logic [1:0] {CMD_SETUP = 2'b00, CMD_GPIO = 2'b01, CMD_DAC = 2'b11} cmd_kind_t;
endpackage : conv_serial_pkg

// >>> bench/conv_serial_ctrl_properties.sv
`timescale 1ns/10ps
module conv_serial_ctrl_properties
	import conv_serial_pkg::*;
(
	input wire logic clock_in, // clock
	input wire logic rst_in, // reset
	input wire logic cs_n_in, // select
	input wire logic dout_out, // data out
	input wire logic adc_result_valid_in, // adc push
	input wire logic temp_result_valid_in, // temp push
	input wire logic dac_load_strobe_n_in, // load pin
	input wire logic [DAC_CH-1:0] dac_buffer_pd_out, // buffers off
	input wire logic clock_mode_sel_hi_out, // mode bit 1
	input wire logic clock_mode_sel_lo_out, // mode bit 0
	input wire logic internal_osc_en_out, // oscillator
	input wire logic sclk_timed_conv_out, // sclk timing
	input wire logic ext_acq_en_out, // ext acquisition
	input wire logic [CNT_W-1:0] fifo_count_out, // adc count
	input wire logic temp_pending_out // temp unread
);
	default clocking dc @(posedge clock_in);
	endclocking
	default disable iff (rst_in);
	// select idle long enough for any posted command to have landed
	sequence cs_idle;
		cs_n_in [*8];
	endsequence
	// load pin held low past its synchroniser
	sequence strobe_held;
		(!dac_load_strobe_n_in) [*4];
	endsequence
	chk_count_bound: assert property (fifo_count_out <= FIFO_FULL)
		else $error("adc count above depth");
	chk_push_kept: assert property (adc_result_valid_in && fifo_count_out < FIFO_FULL
		|=> fifo_count_out >= $past(fifo_count_out)) else $error("push lost");
	chk_full_overwrite: assert property (adc_result_valid_in && fifo_count_out == FIFO_FULL
		|=> fifo_count_out >= 5'h0f) else $error("full push dropped count");
	chk_pop_by_one: assert property (fifo_count_out < $past(fifo_count_out)
		|-> fifo_count_out == $past(fifo_count_out) - 5'h01) else $error("pop skip");
	chk_temp_replace: assert property (temp_result_valid_in |=> temp_pending_out)
		else $error("temp push lost");
	chk_idle_zero: assert property (cs_n_in |-> !dout_out) else $error("dout busy");
	chk_osc_modes: assert property (({clock_mode_sel_hi_out, clock_mode_sel_lo_out} !=
		CLK_MODE_EXT) [*2] |-> internal_osc_en_out && !sclk_timed_conv_out)
		else $error("oscillator decode");
	chk_sclk_mode: assert property (({clock_mode_sel_hi_out, clock_mode_sel_lo_out} ==
		CLK_MODE_EXT) [*2] |-> sclk_timed_conv_out && !internal_osc_en_out)
		else $error("sclk mode decode");
	chk_acq_mode: assert property (({clock_mode_sel_hi_out, clock_mode_sel_lo_out} ==
		CLK_MODE_EXT_ACQ) [*2] |-> ext_acq_en_out) else $error("acq decode");
	chk_strobe_load: assert property (strobe_held |-> dac_buffer_pd_out == 4'h0)
		else $error("strobe did not load");
	chk_idle_quiet: assert property (cs_idle |-> $stable({clock_mode_sel_hi_out,
		clock_mode_sel_lo_out})) else $error("mode moved while idle");
endmodule : conv_serial_ctrl_properties

bind conv_serial_ctrl conv_serial_ctrl_properties i_props (.clock_in(clock_in),
	.rst_in(rst_in), .cs_n_in(cs_n_in), .dout_out(dout_out),
	.adc_result_valid_in(adc_result_valid_in), .temp_result_valid_in(temp_result_valid_in),
	.dac_load_strobe_n_in(dac_load_strobe_n_in), .dac_buffer_pd_out(dac_buffer_pd_out),
	.clock_mode_sel_hi_out(clock_mode_sel_hi_out),
	.clock_mode_sel_lo_out(clock_mode_sel_lo_out),
	.internal_osc_en_out(internal_osc_en_out), .sclk_timed_conv_out(sclk_timed_conv_out),
	.ext_acq_en_out(ext_acq_en_out), .fifo_count_out(fifo_count_out),
	.temp_pending_out(temp_pending_out));

// >>> bench/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
	output logic sclk_out, // serial clock, stands high
	output logic cs_n_out, // chip select
	output logic din_out, // data to device
	input wire logic dout_in // data from device
);
	int half = 6; // half period in ns, widened for sclk-timed mode
	// idle levels before any frame
	initial begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end
	// one frame: n bits msb first from tx, first sixteen bits back in rx
	task automatic xfer(input int n, input logic [23:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n_out = 1'b0;
		#15;
		for (int i = 0; i < n; i++) begin
			din_out = tx[23-i];
			if (i < 16) rx[15-i] = dout_in;
			#(half);
			sclk_out = 1'b0;
			#(half);
			sclk_out = 1'b1;
		end
		cs_n_out = 1'b1;
		din_out = ~din_out; // released line shows no stale bit
		#40;
	endtask : xfer
endmodule : spi_host_model

// >>> bench/conv_serial_ctrl_tb.sv
`timescale 1ns/10ps
module conv_serial_ctrl_tb;
	import conv_serial_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic sclk, cs_n, din, dout, adc_v = 1'b0, temp_v = 1'b0, strobe_n = 1'b1, wake = 1'b1;
	logic [ADC_W-1:0] adc_d = '0;
	logic [TEMP_W-1:0] temp_d = '0;
	logic [DAC_CH*DAC_W-1:0] codes;
	logic [DAC_CH-1:0] pd;
	logic pull, m_hi, m_lo, osc, sclk_t, acq, a0, a1, c0, c1, tp;
	logic [CNT_W-1:0] cnt;
	logic [15:0] rx;
	logic [1:0] mtab [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #2.5 clock_in = ~clock_in;
	conv_serial_ctrl i_conv_serial_ctrl (.clock_in(clock_in), .rst_in(rst_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout),
		.adc_result_valid_in(adc_v), .adc_result_in(adc_d), .temp_result_valid_in(temp_v),
		.temp_result_in(temp_d), .dac_load_strobe_n_in(strobe_n),
		.wakeup_level_select_in(wake), .dac_code_out(codes), .dac_buffer_pd_out(pd),
		.dac_pull_to_ref_out(pull), .clock_mode_sel_hi_out(m_hi),
		.clock_mode_sel_lo_out(m_lo), .internal_osc_en_out(osc),
		.sclk_timed_conv_out(sclk_t), .ext_acq_en_out(acq), .gp_pin_a0_out(a0),
		.gp_pin_a1_out(a1), .gp_pin_c0_out(c0), .gp_pin_c1_out(c1),
		.fifo_count_out(cnt), .temp_pending_out(tp));
	spi_host_model i_spi_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
		.dout_in(dout));
	// count and report one comparison
	task check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// verdict and end of run
	task test_done;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	// hang guard
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end
	task do_reset(input logic w);
		rst_in <= 1'b1;
		wake <= w;
		repeat (20) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (8) @(posedge clock_in);
	endtask : do_reset
	// one frame, then room for the posted command or pop to land
	task frame(input int n, input logic [23:0] tx);
		i_spi_host_model.xfer(n, tx, rx);
		repeat (10) @(posedge clock_in);
	endtask : frame
	// one-cycle push of an adc (t=0) or temperature (t=1) result
	task push(input logic t, input logic [11:0] v);
		@(posedge clock_in);
		adc_v <= !t;
		temp_v <= t;
		adc_d <= v[9:0];
		temp_d <= v;
		@(posedge clock_in);
		adc_v <= 1'b0;
		temp_v <= 1'b0;
		@(posedge clock_in); // count settles before anyone looks at it
	endtask : push
	// main sequence
	initial begin
		do_reset(1'b1);
		check(codes, {4{10'h3ff}});
		check({pd, pull}, 5'h1f);
		check({m_hi, m_lo, osc, sclk_t, acq, cnt, tp}, 11'h500);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			frame(8, {2'h1, mtab[i], 4'h0, 16'h0000});
			i_spi_host_model.half = (mtab[i] == 2'h3) ? 105 : 6;
			check({m_hi, m_lo, osc, sclk_t, acq}, {mtab[i], mtab[i] != 2'h3,
				mtab[i] == 2'h3, mtab[i] == 2'h1});
		end
		$display("test modes done");
		frame(24, {8'h1a, 2'h0, 2'h2, 10'h155, 2'h0});
		check(codes, {4{10'h3ff}});
		frame(24, {8'h1f, 2'h1, 2'h1, 10'h2aa, 2'h3});
		check({codes, pd}, {10'h3ff, 10'h3ff, 10'h2aa, 10'h3ff, 4'hd});
		@(posedge clock_in);
		strobe_n <= 1'b0;
		repeat (6) @(posedge clock_in);
		strobe_n <= 1'b1;
		repeat (4) @(posedge clock_in);
		check({codes, pd}, {10'h3ff, 10'h155, 10'h2aa, 10'h3ff, 4'h0});
		frame(24, {8'h10, 2'h3, 2'h0, 10'h0f0, 2'h0});
		check(codes, {4{10'h0f0}});
		frame(24, {8'h10, 2'h0, 2'h3, 10'h201, 2'h0});
		check(codes, {4{10'h0f0}});
		frame(24, {8'h10, 2'h2, 2'h0, 10'h000, 2'h0});
		check(codes, {10'h201, {3{10'h0f0}}});
		$display("test dac done");
		frame(16, {8'h02, 8'h0a, 8'h00});
		check({rx, c1, c0, a1, a0}, 20'h0000a);
		frame(12, {8'h02, 8'h05, 8'h00});
		frame(4, {4'h5, 20'h0});
		check({c1, c0, a1, a0}, 4'ha);
		$display("test gpio done");
		push(1'b0, 12'h3c1);
		push(1'b0, 12'h005);
		push(1'b0, 12'h2f0);
		check(cnt, 5'h03);
		frame(16, 24'h0);
		check({rx, cnt}, {4'h0, 10'h3c1, 2'h0, 5'h02});
		frame(16, 24'h0);
		check({rx, cnt}, {4'h0, 10'h005, 2'h0, 5'h01});
		frame(16, 24'h0);
		check({rx, cnt}, {4'h0, 10'h2f0, 2'h0, 5'h00});
		frame(16, 24'h0);
		check({rx, cnt}, 21'h0);
		$display("test fifo done");
		push(1'b1, 12'h123);
		push(1'b0, 12'h1ff);
		push(1'b1, 12'hf38);
		frame(16, 24'h0);
		check({rx, tp, cnt}, {4'h0, 12'hf38, 1'b0, 5'h01});
		frame(16, 24'h0);
		check(rx, {4'h0, 10'h1ff, 2'h0});
		$display("test temp done");
		for (int i = 0; i < 17; i++) push(1'b0, 12'(i));
		check(cnt, 5'h10);
		frame(16, 24'h0);
		check({rx, cnt}, {4'h0, 10'h001, 2'h0, 5'h0f});
		$display("test overflow done");
		do_reset(1'b0);
		check({codes, pd, pull}, {40'h0, 4'hf, 1'b0});
		$display("test wake low done");
		test_done();
	end
endmodule : conv_serial_ctrl_tb
